// ===== port_change_pkg.sv
// Package for the root hub port change-flag block: register layout, timing, carriers.
// Assumes a single 250 MHz core clock and a register port reached by code read/write strobes.
package port_change_pkg;

  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned PORT_COUNT       = 2;

  // Register codes: read and write codes per port.
  localparam logic [7:0] PORT1_READ_CODE   = 8'h15;
  localparam logic [7:0] PORT2_READ_CODE   = 8'h16;
  localparam logic [7:0] PORT1_WRITE_CODE  = 8'h95;
  localparam logic [7:0] PORT2_WRITE_CODE  = 8'h96;

  // Bit positions within the port status/control word.
  localparam int unsigned BIT_PRESENT      = 0;
  localparam int unsigned BIT_ENABLED      = 1;
  localparam int unsigned BIT_SUSPENDED    = 2;
  localparam int unsigned BIT_OVERCURRENT  = 3;
  localparam int unsigned BIT_RESET_ACTIVE = 4;
  localparam int unsigned BIT_POWER_ON     = 8;
  localparam int unsigned BIT_SLOW_DEVICE  = 9;
  localparam int unsigned BIT_CONNECT_CHG  = 16;
  localparam int unsigned BIT_ENABLE_CHG   = 17;
  localparam int unsigned BIT_RESUME_CHG   = 18;
  localparam int unsigned BIT_OVERCUR_CHG  = 19;
  localparam int unsigned BIT_RESET_CHG    = 20;
  localparam int unsigned CHANGE_LSB       = 16;
  localparam int unsigned CHANGE_WIDTH     = 5;

  // Timing: reset signalling and resume resynchronisation.
  localparam int unsigned RESET_TIME_MS    = 10;
  localparam int unsigned RESYNC_TIME_MS   = 3;
  localparam int unsigned RESUME_PULSE_MS  = 20;
  localparam int unsigned RESET_CYCLES     = RESET_TIME_MS * CLK_MHZ * 1000;
  localparam int unsigned RESYNC_CYCLES    = RESYNC_TIME_MS * CLK_MHZ * 1000;
  localparam int unsigned RESUME_CYCLES    = RESUME_PULSE_MS * CLK_MHZ * 1000;
  localparam int unsigned TIMER_WIDTH      = 24;

  // Hardware events seen by one port.
  typedef struct packed {
    logic present;
    logic slow_device;
    logic overcurrent;
    logic enable_lost;
    logic eop_done;
    logic resume_req;
  } port_events_s;

  // Lower status bits owned by the rest of the port.
  typedef struct packed {
    logic power_on;
    logic reset_active;
    logic suspended;
    logic enabled;
  } port_state_s;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_RESET,
    SEQ_RESUME,
    SEQ_RESYNC
  } seq_state_e;

endpackage

// ===== pin_sync.sv
// Three-stage input synchroniser with agreement filter for asynchronous port pins.
// Assumes core_clk domain; output changes once stages two and three agree.
`timescale 1ns/1ps
module pin_sync import port_change_pkg::*; #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // Pins and filtered level
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] agree;

  assign agree = ~(s2_q ^ s3_q);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s1_q      <= '0;
      s2_q      <= '0;
      s3_q      <= '0;
      level_out <= '0;
    end else begin
      s1_q      <= pin_in;
      s2_q      <= s1_q;
      s3_q      <= s2_q;
      level_out <= (agree & s3_q) | (~agree & level_out);
    end
  end

endmodule

// ===== root_port_status_control.sv
// Per-port change flags, slow-device indication and power clear for a two-port root hub.
// Assumes a synchronous register port with read/write codes and raw pin inputs per port.
//
// Functional notes
// - Set reset-done change flag when the 10 ms reset signalling ends.
// - Change flags clear on a written one, resume-done also when reset-done sets; zero leaves them unchanged.
// - Overcurrent change flag sets whenever the port overcurrent indicator changes while per_port_oc is set.
// - Resume-done flag sets after resume pulse, slow EOP and 3 ms resync.
// - Resume-done flag clears whenever the reset-done flag becomes set.
// - Enable-lost flag sets only on hardware loss of port enable.
// - Connect change flag sets on every connect or disconnect of a non-fixed port.
// - Reset, enable or suspend write on empty port sets connect change.
// - Fixed-device port sets connect change only after a root hub reset.
// - Read bit 9 shows the synchronised slow pin, whether or not a device is present.
// - Writing one to bit 9 clears port power; zero does nothing.
// - Writes arriving during a bus transaction are held until it finishes.
// - Reset-active clears in the same cycle the reset-done flag sets.
// - Reset write on empty port starts no reset, only raises connect change.
`timescale 1ns/1ps
module root_port_status_control import port_change_pkg::*; #(
  parameter int unsigned NPORTS        = PORT_COUNT,
  parameter int unsigned RESET_COUNT   = RESET_CYCLES,
  parameter int unsigned RESUME_COUNT  = RESUME_CYCLES,
  parameter int unsigned RESYNC_COUNT  = RESYNC_CYCLES,
  parameter logic [1:0]  FIXED_DEVICES = 2'h0
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  // Register port
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [7:0]           reg_code,
  input  wire logic [31:0]          reg_wdata,
  output logic      [31:0]          reg_rdata,
  // Transaction in progress on the bus
  input  wire logic                 xfer_busy,
  // Port pins and events
  input  wire logic [NPORTS-1:0]    pin_present,
  input  wire logic [NPORTS-1:0]    pin_slow,
  input  wire logic [NPORTS-1:0]    pin_overcurrent,
  input  wire logic [NPORTS-1:0]    enable_lost,
  input  wire logic [NPORTS-1:0]    eop_done,
  input  wire logic [NPORTS-1:0]    resume_req,
  input  wire logic                 per_port_oc,
  // Port control outputs
  output logic      [NPORTS-1:0]    port_reset_drive,
  output logic      [NPORTS-1:0]    port_resume_drive,
  output logic      [NPORTS-1:0]    port_power_on
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation.

  logic [NPORTS-1:0] present_s;
  logic [NPORTS-1:0] slow_s;
  logic [NPORTS-1:0] oc_s;

  pin_sync #(.WIDTH(3 * NPORTS)) u_sync (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .pin_in    ({pin_present, pin_slow, pin_overcurrent}),
    .level_out ({present_s, slow_s, oc_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write capture, held while a transaction is in progress.

  logic        pend_q;
  logic        pend_d;
  logic [1:0]  pend_port_q;
  logic [31:0] pend_data_q;
  logic        wr_hit;
  logic [1:0]  wr_port;
  logic        apply;

  assign wr_hit  = reg_wr && (reg_code == PORT1_WRITE_CODE || reg_code == PORT2_WRITE_CODE);
  assign wr_port = (reg_code == PORT1_WRITE_CODE) ? 2'h1 : 2'h2;
  assign apply   = pend_q && !xfer_busy;
  assign pend_d  = wr_hit ? 1'b1 : (apply ? 1'b0 : pend_q);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pend_q      <= 1'b0;
      pend_port_q <= 2'h0;
      pend_data_q <= 32'h0;
    end else begin
      pend_q <= pend_d;
      if (wr_hit) begin
        pend_port_q <= wr_port;
        pend_data_q <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-port logic.

  logic [31:0] port_word [NPORTS];
  logic        rst_done_q;

  // A root hub reset has completed once sys_rst has dropped.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rst_done_q <= 1'b0;
    end else begin
      rst_done_q <= 1'b1;
    end
  end

  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    seq_state_e              st_q;
    seq_state_e              st_d;
    logic [TIMER_WIDTH-1:0]  tmr_q;
    logic [TIMER_WIDTH-1:0]  tmr_d;
    logic [CHANGE_WIDTH-1:0] chg_q;
    logic [CHANGE_WIDTH-1:0] chg_set;
    logic [CHANGE_WIDTH-1:0] chg_clr;
    port_state_s             ps_q;
    port_state_s             ps_d;
    logic                    present_q;
    logic                    oc_q;
    logic                    fixed_seen_q;
    logic                    wr_me;
    logic                    wr_reset;
    logic                    wr_enable;
    logic                    wr_suspend;
    logic                    wr_clr_en;
    logic                    wr_power_set;
    logic                    wr_power_clr;
    logic                    reset_end;
    logic                    resync_end;
    logic                    conn_evt;
    logic                    empty_cmd;
    logic                    fixed_evt;
    logic                    hw_disable;

    assign wr_me        = apply && (pend_port_q == 2'(p + 1));
    assign wr_clr_en    = wr_me && pend_data_q[BIT_PRESENT];
    assign wr_enable    = wr_me && pend_data_q[BIT_ENABLED];
    assign wr_suspend   = wr_me && pend_data_q[BIT_SUSPENDED];
    assign wr_reset     = wr_me && pend_data_q[BIT_RESET_ACTIVE];
    assign wr_power_set = wr_me && pend_data_q[BIT_POWER_ON];
    assign wr_power_clr = wr_me && pend_data_q[BIT_SLOW_DEVICE];
    assign reset_end    = (st_q == SEQ_RESET) && (tmr_q == '0);
    assign resync_end   = (st_q == SEQ_RESYNC) && (tmr_q == '0);
    assign hw_disable   = ps_q.enabled && (enable_lost[p] || !present_s[p] || oc_s[p]);
    assign empty_cmd    = !present_s[p] && (wr_reset || wr_enable || wr_suspend);
    assign fixed_evt    = rst_done_q && !fixed_seen_q && present_s[p];
    assign conn_evt     = FIXED_DEVICES[p] ? fixed_evt : (present_s[p] != present_q);

    // Event sources per change flag; sets beat same-cycle clears below.
    assign chg_set[BIT_CONNECT_CHG - CHANGE_LSB] = conn_evt || empty_cmd;
    assign chg_set[BIT_ENABLE_CHG - CHANGE_LSB]  = hw_disable;
    assign chg_set[BIT_RESUME_CHG - CHANGE_LSB]  = resync_end;
    assign chg_set[BIT_OVERCUR_CHG - CHANGE_LSB] = per_port_oc && (oc_s[p] != oc_q);
    assign chg_set[BIT_RESET_CHG - CHANGE_LSB]   = reset_end;
    assign chg_clr = wr_me ? pend_data_q[CHANGE_LSB +: CHANGE_WIDTH] : '0;

    always_comb begin
      st_d  = st_q;
      tmr_d = (tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
      ps_d  = ps_q;
      if (wr_power_set) begin
        ps_d.power_on = 1'b1;
      end
      if (wr_enable && present_s[p]) begin
        ps_d.enabled = 1'b1;
      end
      if (wr_clr_en || hw_disable) begin
        ps_d.enabled = 1'b0;
      end
      if (wr_suspend && present_s[p]) begin
        ps_d.suspended = 1'b1;
      end
      case (st_q)
        SEQ_IDLE: begin
          if (wr_reset && present_s[p]) begin
            st_d            = SEQ_RESET;
            tmr_d           = TIMER_WIDTH'(RESET_COUNT - 1);
            ps_d.reset_active = 1'b1;
          end else if (ps_q.suspended && resume_req[p]) begin
            st_d  = SEQ_RESUME;
            tmr_d = TIMER_WIDTH'(RESUME_COUNT - 1);
          end
        end
        SEQ_RESET: begin
          if (reset_end) begin
            st_d              = SEQ_IDLE;
            ps_d.reset_active = 1'b0;
            ps_d.enabled      = 1'b1;
          end
        end
        SEQ_RESUME: begin
          if (tmr_q == '0 && eop_done[p]) begin
            st_d  = SEQ_RESYNC;
            tmr_d = TIMER_WIDTH'(RESYNC_COUNT - 1);
          end
        end
        SEQ_RESYNC: begin
          if (resync_end) begin
            st_d           = SEQ_IDLE;
            ps_d.suspended = 1'b0;
          end
        end
        default: begin
          st_d = SEQ_IDLE;
        end
      endcase
      if (wr_power_clr || oc_s[p]) begin
        ps_d = '0;
        st_d = SEQ_IDLE;
      end
    end

    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        st_q         <= SEQ_IDLE;
        tmr_q        <= '0;
        ps_q         <= '0;
        chg_q        <= '0;
        present_q    <= 1'b0;
        oc_q         <= 1'b0;
        fixed_seen_q <= 1'b0;
      end else begin
        st_q         <= st_d;
        tmr_q        <= tmr_d;
        ps_q         <= ps_d;
        present_q    <= present_s[p];
        oc_q         <= oc_s[p];
        fixed_seen_q <= fixed_seen_q || fixed_evt;
        chg_q        <= chg_set | (chg_q & ~chg_clr);
        if (reset_end) begin
          chg_q[BIT_RESUME_CHG - CHANGE_LSB] <= 1'b0;
        end
      end
    end

    always_comb begin
      port_word[p]                   = 32'h0;
      port_word[p][BIT_PRESENT]      = present_s[p];
      port_word[p][BIT_ENABLED]      = ps_q.enabled;
      port_word[p][BIT_SUSPENDED]    = ps_q.suspended;
      port_word[p][BIT_OVERCURRENT]  = per_port_oc && oc_s[p];
      port_word[p][BIT_RESET_ACTIVE] = ps_q.reset_active;
      port_word[p][BIT_POWER_ON]     = ps_q.power_on;
      port_word[p][BIT_SLOW_DEVICE]  = slow_s[p];
      port_word[p][CHANGE_LSB +: CHANGE_WIDTH] = chg_q;
    end

    assign port_reset_drive[p]  = (st_q == SEQ_RESET);
    assign port_resume_drive[p] = (st_q == SEQ_RESUME);
    assign port_power_on[p]     = ps_q.power_on;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data register.

  logic [31:0] rdata_d;

  assign rdata_d = !reg_rd                     ? reg_rdata    :
                   (reg_code == PORT1_READ_CODE) ? port_word[0] :
                   (reg_code == PORT2_READ_CODE) ? port_word[NPORTS-1] : 32'h0;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

endmodule

// ===== usb_port_device.sv
// Behavioural downstream device on one root port.
// Assumes the core clock; attach and speed come from the bench.
`timescale 1ns/1ps
module usb_port_device (
  // Clock
  input  wire logic core_clk,
  // Bench controls
  input  wire logic attach,
  input  wire logic low_speed,
  // Port lines
  input  wire logic resume_drive,
  output logic      present,
  output logic      slow,
  output logic      eop
);
  logic drv_q  = 1'b0;
  logic slow_q = 1'b0;
  logic eop_q  = 1'b0;
  assign present = attach;
  assign slow    = slow_q;
  assign eop     = eop_q;
  // The end of packet is ready once the resume pulse has run for two cycles.
  // A detached port has no speed level, so the line wanders.
  always @(posedge core_clk) begin
    drv_q  <= resume_drive;
    eop_q  <= drv_q & resume_drive;
    slow_q <= attach ? low_speed : ~slow_q;
  end
endmodule

// ===== port_change_props.sv
// Checker for the root port status block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module port_change_props import port_change_pkg::*; #(
  parameter int unsigned NPORTS       = PORT_COUNT,
  parameter int unsigned RESET_COUNT  = RESET_CYCLES,
  parameter int unsigned RESUME_COUNT = RESUME_CYCLES
) (
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              sys_rst,
  // Register port
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_code,
  input wire logic [31:0]       reg_wdata,
  input wire logic [31:0]       reg_rdata,
  input wire logic              xfer_busy,
  // Port outputs
  input wire logic [NPORTS-1:0] port_reset_drive,
  input wire logic [NPORTS-1:0] port_resume_drive,
  input wire logic [NPORTS-1:0] port_power_on
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [31:0] rst_cnt_q;
  logic [31:0] res_cnt_q;
  always_ff @(posedge core_clk) begin
    rst_cnt_q <= (sys_rst || !port_reset_drive[0]) ? 32'h0 : rst_cnt_q + 32'h1;
    res_cnt_q <= (sys_rst || !port_resume_drive[0]) ? 32'h0 : res_cnt_q + 32'h1;
  end
  ////////////////////////////////////////
  reset_len_a: assert property ($fell(port_reset_drive[0]) |->
    rst_cnt_q >= RESET_COUNT - 2 && rst_cnt_q <= RESET_COUNT + 2) else $error("reset length");
  reset_hold_a: assert property ($rose(port_reset_drive[0]) |-> port_reset_drive[0][*8])
    else $error("reset too short");
  resume_len_a: assert property ($fell(port_resume_drive[0]) |->
    res_cnt_q >= RESUME_COUNT - 2 && res_cnt_q <= RESUME_COUNT + 2) else $error("resume length");
  reset_bit_a: assert property (reg_rd && reg_code == PORT1_READ_CODE |=>
    reg_rdata[4] == $past(port_reset_drive[0])) else $error("reset bit");
  power_bit_a: assert property (reg_rd && reg_code == PORT1_READ_CODE |=>
    reg_rdata[8] == $past(port_power_on[0])) else $error("power bit");
  power_clear_a: assert property (reg_wr && reg_code == PORT2_WRITE_CODE && reg_wdata[9]
    && !reg_wdata[8] ##1 !xfer_busy |=> !port_power_on[1]) else $error("power clear");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
  bad_code_a: assert property (reg_rd && reg_code != PORT1_READ_CODE
    && reg_code != PORT2_READ_CODE |=> reg_rdata == 32'h0) else $error("bad code data");
  reserved_zero_a: assert property (reg_rd |=> reg_rdata[31:21] == 11'h0
    && reg_rdata[15:10] == 6'h0 && reg_rdata[7:5] == 3'h0) else $error("reserved bits");
  reset_out_a: assert property ($fell(sys_rst) |-> port_power_on == '0
    && port_reset_drive == '0 && reg_rdata == 32'h0) else $error("reset outputs");
  cover property ($fell(port_reset_drive[0]));
  cover property ($fell(port_resume_drive[0]));
  cover property (reg_wr && reg_wdata[9]);
endmodule

bind root_port_status_control port_change_props #(.NPORTS(NPORTS), .RESET_COUNT(RESET_COUNT),
  .RESUME_COUNT(RESUME_COUNT)) port_change_props_inst (.core_clk(core_clk), .sys_rst(sys_rst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_code(reg_code), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .xfer_busy(xfer_busy), .port_reset_drive(port_reset_drive),
  .port_resume_drive(port_resume_drive), .port_power_on(port_power_on));

// ===== root_port_status_control_bench.sv
// Self-checking bench for the root port status block.
// Assumes short reset and resume counts and one device model per port.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin error_cnt++; \
  $display("ERROR %s expected %h seen %h", n, e, s); end end
module root_port_status_control_bench import port_change_pkg::*;;
  localparam logic [31:0] CMDS [3] = '{32'h2, 32'h4, 32'h10};
  logic        core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        xfer_busy = 1'b0, per_port_oc = 1'b0;
  logic [7:0]  reg_code = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_q;
  logic [1:0]  attach = 2'h0, low_speed = 2'h0, pin_overcurrent = 2'h0;
  logic [1:0]  enable_lost = 2'h0, resume_req = 2'h0, pin_present, pin_slow, eop_done;
  logic [1:0]  port_reset_drive, port_resume_drive, port_power_on;
  int          error_cnt = 0, checked = 0;
  root_port_status_control #(.RESET_COUNT(20), .RESUME_COUNT(20), .RESYNC_COUNT(12),
    .FIXED_DEVICES(2'h2))
    root_port_status_control_inst (.core_clk(core_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_code(reg_code), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .xfer_busy(xfer_busy), .pin_present(pin_present), .pin_slow(pin_slow),
    .pin_overcurrent(pin_overcurrent), .enable_lost(enable_lost), .eop_done(eop_done),
    .resume_req(resume_req), .per_port_oc(per_port_oc), .port_reset_drive(port_reset_drive),
    .port_resume_drive(port_resume_drive), .port_power_on(port_power_on));
  for (genvar i = 0; i < 2; i++) begin : dev
    usb_port_device usb_port_device_inst (.core_clk(core_clk), .attach(attach[i]),
      .low_speed(low_speed[i]), .resume_drive(port_resume_drive[i]), .present(pin_present[i]),
      .slow(pin_slow[i]), .eop(eop_done[i]));
  end
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  ////////////////////////////////////////
  task automatic print_verdict;
    if (error_cnt == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] c, input logic [31:0] d);
    @(negedge core_clk); reg_wr = 1'b1; reg_code = c; reg_wdata = d;
    @(negedge core_clk); reg_wr = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic rd(input logic [7:0] c);
    @(negedge core_clk); reg_rd = 1'b1; reg_code = c;
    @(negedge core_clk); reg_rd = 1'b0; rd_q = reg_rdata;
  endtask
  task automatic wait_drop(input int s);
    int n;
    for (n = 0; n < 200; n++) begin
      @(negedge core_clk);
      if ((s ? port_reset_drive[0] : port_resume_drive[0]) === 1'b0) break;
    end
    if (n == 200) begin
      error_cnt++;
      print_verdict();
    end
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h00592f1c));
    repeat (16) @(negedge core_clk);
    sys_rst = 1'b0;
    rd(PORT1_READ_CODE); `CHK("reset word", 32'h0, rd_q)
    wr(PORT1_WRITE_CODE, 32'h100);
    wr(PORT2_WRITE_CODE, 32'h100);
    for (int i = 0; i < 3; i++) begin
      wr(PORT2_WRITE_CODE, 32'h10000);
      rd(PORT2_READ_CODE); `CHK("connect chg cleared", 1'b0, rd_q[16])
      wr(PORT2_WRITE_CODE, CMDS[i]);
      rd(PORT2_READ_CODE); `CHK("connect chg empty", 1'b1, rd_q[16])
      `CHK("no reset empty", 1'b0, port_reset_drive[1])
      wr(PORT2_WRITE_CODE, 32'h0);
      rd(PORT2_READ_CODE); `CHK("zero write kept", 1'b1, rd_q[16])
    end
    wr(PORT2_WRITE_CODE, 32'h10002);
    rd(PORT2_READ_CODE); `CHK("set beats clear", 1'b1, rd_q[16])
    wr(PORT2_WRITE_CODE, 32'h10000);
    attach[1] = 1'b1;
    repeat (8) @(negedge core_clk);
    rd(PORT2_READ_CODE); `CHK("fixed connect", 1'b1, rd_q[16])
    wr(PORT2_WRITE_CODE, 32'h10000);
    attach[1] = 1'b0;
    repeat (8) @(negedge core_clk);
    rd(PORT2_READ_CODE); `CHK("fixed no detach", 1'b0, rd_q[16])
    low_speed[0] = 1'($urandom_range(1, 0));
    attach[0] = 1'b1;
    repeat (8) @(negedge core_clk);
    rd(PORT1_READ_CODE); `CHK("connect chg", 1'b1, rd_q[16])
    `CHK("slow device", low_speed[0], rd_q[9])
    wr(PORT1_WRITE_CODE, 32'h10002);
    wr(PORT1_WRITE_CODE, 32'h4);
    @(negedge core_clk); resume_req[0] = 1'b1;
    @(negedge core_clk); resume_req[0] = 1'b0;
    repeat (2) @(negedge core_clk);
    wait_drop(0);
    repeat (20) @(negedge core_clk);
    rd(PORT1_READ_CODE); `CHK("resume done", 1'b1, rd_q[18])
    xfer_busy = 1'b1;
    wr(PORT1_WRITE_CODE, 32'h10);
    repeat ($urandom_range(4, 1)) @(negedge core_clk);
    `CHK("reset deferred", 1'b0, port_reset_drive[0])
    xfer_busy = 1'b0;
    repeat (3) @(negedge core_clk);
    `CHK("reset driven", 1'b1, port_reset_drive[0])
    wait_drop(1);
    rd(PORT1_READ_CODE); `CHK("reset done", 1'b1, rd_q[20])
    `CHK("reset active off", 1'b0, rd_q[4])
    `CHK("resume flag off", 1'b0, rd_q[18])
    @(negedge core_clk); enable_lost[0] = 1'b1;
    @(negedge core_clk); enable_lost[0] = 1'b0;
    rd(PORT1_READ_CODE); `CHK("enable lost chg", 1'b1, rd_q[17])
    `CHK("enable off", 1'b0, rd_q[1])
    wr(PORT1_WRITE_CODE, 32'h20002);
    wr(PORT1_WRITE_CODE, 32'h1);
    rd(PORT1_READ_CODE); `CHK("no chg on sw disable", 1'b0, rd_q[17])
    per_port_oc = 1'b1;
    pin_overcurrent[0] = 1'b1;
    repeat (8) @(negedge core_clk);
    rd(PORT1_READ_CODE); `CHK("overcurrent chg", 1'b1, rd_q[19])
    rd(8'h33);
    wr(PORT2_WRITE_CODE, 32'h0); `CHK("power kept", 1'b1, port_power_on[1])
    wr(PORT2_WRITE_CODE, 32'h200); `CHK("power cleared", 1'b0, port_power_on[1])
    print_verdict();
  end
endmodule
